// [inc/dlecr_map.svh]
// Register indices, field positions, reset values and strap codes
`ifndef DLECR_MAP_SVH
`define DLECR_MAP_SVH

// =====================================================================
// Register indices; byte address is four times the index
`define DLECR_IDX_LINK 6'h04
`define DLECR_IDX_EQ 6'h05
`define DLECR_ADDR_W 8

// =====================================================================
// Link control and status fields
`define DLECR_LINK_LOCK_BIT 7
`define DLECR_LINK_ODIS_BIT 6
`define DLECR_LINK_PRBS_BIT 5
`define DLECR_LINK_SLEEP_BIT 4
`define DLECR_LINK_IF_HI 3
`define DLECR_LINK_IF_LO 2
`define DLECR_LINK_BACK_BIT 1
`define DLECR_LINK_FORE_BIT 0

// =====================================================================
// Equalizer and conversion fields
`define DLECR_EQ_CMD_BIT 7
`define DLECR_EQ_CUT_HI 6
`define DLECR_EQ_CUT_LO 5
`define DLECR_EQ_BOOST_BIT 4
`define DLECR_EQ_GAIN_HI 3
`define DLECR_EQ_GAIN_LO 0

// =====================================================================
// Reset values and strap-driven defaults
`define DLECR_RST_ODIS 1'h0
`define DLECR_RST_PRBS 1'h0
`define DLECR_RST_SLEEP 1'h0
`define DLECR_RST_BACK 1'h1
`define DLECR_RST_FORE 1'h1
`define DLECR_RST_CMD 1'h0
`define DLECR_RST_CUT 2'h1
`define DLECR_RST_BOOST 1'h0
`define DLECR_GAIN_EQS_HIGH 4'h4
`define DLECR_GAIN_EQS_LOW 4'h9
`define DLECR_GAIN_BAD_TOP 2'h3

`endif

// [inc/dlecr_pkg.sv]
// Types shared by the link configuration register bank
package dlecr_pkg;

   typedef enum logic [1:0] {
      DLECR_IF_I2C = 2'h0,
      DLECR_IF_UART = 2'h1,
      DLECR_IF_OFF_A = 2'h2,
      DLECR_IF_OFF_B = 2'h3
   } dlecr_if_e;

   typedef enum logic [1:0] {
      DLECR_HIT_NONE = 2'h0,
      DLECR_HIT_LINK = 2'h1,
      DLECR_HIT_EQ = 2'h3
   } dlecr_hit_e;

   typedef enum logic {
      DLECR_ST_WAIT = 1'b0,
      DLECR_ST_DONE = 1'b1
   } dlecr_strap_e;

   typedef struct packed {
      dlecr_strap_e st;
      logic sleep;
      logic [3:0] gain;
   } dlecr_strap_s;

   typedef struct packed {
      logic init_done;
      logic out_dis;
      logic prbs_en;
      logic sleep;
      dlecr_if_e if_sel;
      logic back_en;
      logic fore_en;
      logic cmd_only;
      logic [1:0] cutoff;
      logic boost_dis;
      logic [3:0] gain;
      logic [7:0] rdata;
   } dlecr_regs_s;

endpackage

// [logic/dlecr_strap.sv]
// Captures the configuration pins once after reset release
`timescale 1ns/100ps
`include "dlecr_map.svh"

module dlecr_strap
   import dlecr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic control_direction_pin,
   input wire logic mode_select_pin,
   input wire logic equalizer_default_pin,
   output logic strap_valid,
   output logic strap_sleep,
   output logic [3:0] strap_gain
);

   dlecr_strap_s s_q;
   dlecr_strap_s s_d;

   // =====================================================================
   // Pins are sampled by a clocked edge, never by the async reset
   always_comb begin
      s_d = s_q;
      unique case (s_q.st)
         DLECR_ST_WAIT: begin
            s_d.st = DLECR_ST_DONE;
            s_d.sleep = control_direction_pin & mode_select_pin;
            s_d.gain = equalizer_default_pin ? `DLECR_GAIN_EQS_HIGH
                                             : `DLECR_GAIN_EQS_LOW;
         end
         DLECR_ST_DONE: begin
            s_d = s_q;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{st: DLECR_ST_WAIT, sleep: 1'b0, gain: 4'h0};
      end else begin
         s_q <= s_d;
      end
   end

   assign strap_valid = (s_q.st == DLECR_ST_DONE);
   assign strap_sleep = s_q.sleep;
   assign strap_gain = s_q.gain;

endmodule // dlecr_strap

// [logic/dlecr_regs.sv]
// APB register bank for link control and equalizer configuration
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "dlecr_map.svh"

// What this block does
// - Link bit 4 puts the device to sleep when set, defaulting from two pins.
// - Link bits 3:2 pick I2C (00), UART (01) or no peripheral port (1x).
// - Link bit 1 enables sending on the back channel and resets to 1.
// - Link bit 0 enables receiving on the fore channel and resets to 1.
// - Equalizer bit 7 set drops the register address from I2C conversion.
// - Equalizer bits 6:5 choose the highpass cutoff and reset to 01.
// - Equalizer bits 3:0 set boost gain 0000 to 1011; 11xx is not used.
// - The gain loads 0100 with the default pin high and 1001 with it low.
module dlecr_regs
   import dlecr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DLECR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_acquired_flag,
   input wire logic control_direction_pin,
   input wire logic mode_select_pin,
   input wire logic equalizer_default_pin,
   output logic sleep_mode,
   output logic output_disable,
   output logic pattern_test_enable,
   output logic [1:0] peripheral_interface_select,
   output logic i2c_port_enable,
   output logic uart_port_enable,
   output logic back_channel_send_enable,
   output logic fore_channel_receive_enable,
   output logic command_byte_only_select,
   output logic [1:0] equalizer_cutoff_select,
   output logic boost_disable,
   output logic [3:0] equalizer_gain_select
);

   dlecr_regs_s r_q;
   dlecr_regs_s r_d;
   logic strap_valid;
   logic strap_sleep;
   logic [3:0] strap_gain;
   dlecr_hit_e hit;
   logic wr_acc;

   // =====================================================================
   // Address decode, shared by the read and write paths
   function automatic dlecr_hit_e dlecr_decode(
      input logic [`DLECR_ADDR_W-1:0] a);
      if (a == {`DLECR_IDX_LINK, 2'b00}) begin
         return DLECR_HIT_LINK;
      end else if (a == {`DLECR_IDX_EQ, 2'b00}) begin
         return DLECR_HIT_EQ;
      end else begin
         return DLECR_HIT_NONE;
      end
   endfunction

   function automatic logic [7:0] dlecr_read(
      input dlecr_hit_e h, input dlecr_regs_s r, input logic lock);
      unique case (h)
         DLECR_HIT_LINK: return {lock, r.out_dis, r.prbs_en, r.sleep,
                                 r.if_sel, r.back_en, r.fore_en};
         DLECR_HIT_EQ: return {r.cmd_only, r.cutoff, r.boost_dis, r.gain};
         default: return 8'h00;
      endcase
   endfunction

   dlecr_strap dlecr_strap_inst (
      .pclk(pclk),
      .presetn(presetn),
      .control_direction_pin(control_direction_pin),
      .mode_select_pin(mode_select_pin),
      .equalizer_default_pin(equalizer_default_pin),
      .strap_valid(strap_valid),
      .strap_sleep(strap_sleep),
      .strap_gain(strap_gain)
   );

   assign hit = dlecr_decode(paddr);
   // Bus stalls until strap defaults are in place, so no write is lost
   assign pready = r_q.init_done;
   assign pslverr = psel & penable & (hit == DLECR_HIT_NONE);
   assign wr_acc = psel & penable & pwrite & pready;

   // =====================================================================
   // Next-state logic
   always_comb begin
      dlecr_regs_s base;
      // Strap defaults go in first, so a read captured on the init
      // edge already returns them instead of the bare reset values
      base = r_q;
      if (!r_q.init_done && strap_valid) begin
         base.init_done = 1'b1;
         base.sleep = strap_sleep;
         base.gain = strap_gain;
      end
      r_d = base;
      // Read data is captured while selected so it comes from a flop
      if (psel && !pwrite) begin
         r_d.rdata = dlecr_read(hit, base, link_acquired_flag);
      end
      if (wr_acc && hit == DLECR_HIT_LINK) begin
         r_d.out_dis = pwdata[`DLECR_LINK_ODIS_BIT];
         r_d.prbs_en = pwdata[`DLECR_LINK_PRBS_BIT];
         r_d.sleep = pwdata[`DLECR_LINK_SLEEP_BIT];
         r_d.if_sel = dlecr_if_e'(
            pwdata[`DLECR_LINK_IF_HI:`DLECR_LINK_IF_LO]);
         r_d.back_en = pwdata[`DLECR_LINK_BACK_BIT];
         r_d.fore_en = pwdata[`DLECR_LINK_FORE_BIT];
      end
      if (wr_acc && hit == DLECR_HIT_EQ) begin
         r_d.cmd_only = pwdata[`DLECR_EQ_CMD_BIT];
         r_d.cutoff = pwdata[`DLECR_EQ_CUT_HI:`DLECR_EQ_CUT_LO];
         r_d.boost_dis = pwdata[`DLECR_EQ_BOOST_BIT];
         // Unused gain codes are dropped; the old gain stays
         if (pwdata[`DLECR_EQ_GAIN_HI:`DLECR_EQ_GAIN_HI-1]
             != `DLECR_GAIN_BAD_TOP) begin
            r_d.gain = pwdata[`DLECR_EQ_GAIN_HI:`DLECR_EQ_GAIN_LO];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '{init_done: 1'b0,
                  out_dis: `DLECR_RST_ODIS,
                  prbs_en: `DLECR_RST_PRBS,
                  sleep: `DLECR_RST_SLEEP,
                  if_sel: DLECR_IF_I2C,
                  back_en: `DLECR_RST_BACK,
                  fore_en: `DLECR_RST_FORE,
                  cmd_only: `DLECR_RST_CMD,
                  cutoff: `DLECR_RST_CUT,
                  boost_dis: `DLECR_RST_BOOST,
                  gain: `DLECR_GAIN_EQS_HIGH,
                  rdata: 8'h00};
      end else begin
         r_q <= r_d;
      end
   end

   // =====================================================================
   // Outputs
   assign prdata = {24'h000000, r_q.rdata};
   assign sleep_mode = r_q.sleep;
   assign output_disable = r_q.out_dis;
   assign pattern_test_enable = r_q.prbs_en;
   assign peripheral_interface_select = r_q.if_sel;
   assign i2c_port_enable = (r_q.if_sel == DLECR_IF_I2C);
   assign uart_port_enable = (r_q.if_sel == DLECR_IF_UART);
   assign back_channel_send_enable = r_q.back_en;
   assign fore_channel_receive_enable = r_q.fore_en;
   assign command_byte_only_select = r_q.cmd_only;
   assign equalizer_cutoff_select = r_q.cutoff;
   assign boost_disable = r_q.boost_dis;
   assign equalizer_gain_select = r_q.gain;

   // =====================================================================
   // Checks
   sleep_strap_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(r_q.init_done) |-> sleep_mode == $past(strap_sleep))
      else $error("sleep default not taken from pins");

   if_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_LINK |=>
         peripheral_interface_select == $past(pwdata[3:2])
         && i2c_port_enable == ($past(pwdata[3:2]) == 2'h0))
      else $error("peripheral select not written");

   back_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_LINK |=>
         back_channel_send_enable == $past(pwdata[1]))
      else $error("back channel enable not written");

   fore_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_LINK |=>
         fore_channel_receive_enable == $past(pwdata[0]))
      else $error("fore channel enable not written");

   cmd_only_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_EQ |=>
         command_byte_only_select == $past(pwdata[7]))
      else $error("command byte select not written");

   cutoff_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_EQ |=>
         equalizer_cutoff_select == $past(pwdata[6:5]))
      else $error("cutoff not written");

   gain_guard_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_EQ && pwdata[3:2] == 2'h3 |=>
         $stable(equalizer_gain_select))
      else $error("unused gain code accepted");

   gain_strap_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(r_q.init_done) |-> equalizer_gain_select == $past(strap_gain)
         && (equalizer_gain_select == 4'h4 || equalizer_gain_select == 4'h9))
      else $error("gain default not taken from pin");

   lock_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !pwrite && hit == DLECR_HIT_LINK |=>
         prdata[7] == $past(link_acquired_flag))
      else $error("lock bit not reflected");

   boost_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && hit == DLECR_HIT_EQ |=> boost_disable == $past(pwdata[4]))
      else $error("boost disable not written");

endmodule // dlecr_regs

// [dv/dlecr_mcu.sv]
// Microcontroller model issuing APB transfers to the register bank
`timescale 1ns/100ps

module dlecr_mcu (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // ==================================================================
   // One transfer
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err,
      output logic tmo);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      tmo = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so a stale value never looks valid
      paddr <= ~a;
      pwdata <= ~d;
      pwrite <= ~wr;
   endtask
endmodule // dlecr_mcu

// [dv/dlecr_regs_tb.sv]
// Self-checking bench for the link configuration register bank
`timescale 1ns/100ps
`include "dlecr_map.svh"

module dlecr_regs_tb;
   import dlecr_pkg::*;
   localparam logic [7:0] A_LINK = {`DLECR_IDX_LINK, 2'b00};
   localparam logic [7:0] A_EQ = {`DLECR_IDX_EQ, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic lock = 1'b1;
   logic cdir = 1'b1;
   logic msel = 1'b1;
   logic eqd = 1'b0;
   logic sleep, odis, prbs, i2c_en, uart_en, back, fore, cmd, bdis;
   logic [1:0] ifs, cut;
   logic [3:0] gain;
   logic e;
   int num_errors = 0;
   int n_checks = 0;

   always #50 pclk = ~pclk;

   dlecr_mcu dlecr_mcu_inst (.pclk(pclk), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   dlecr_regs dlecr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_acquired_flag(lock), .control_direction_pin(cdir),
      .mode_select_pin(msel), .equalizer_default_pin(eqd),
      .sleep_mode(sleep), .output_disable(odis), .pattern_test_enable(prbs),
      .peripheral_interface_select(ifs), .i2c_port_enable(i2c_en),
      .uart_port_enable(uart_en), .back_channel_send_enable(back),
      .fore_channel_receive_enable(fore), .command_byte_only_select(cmd),
      .equalizer_cutoff_select(cut), .boost_disable(bdis),
      .equalizer_gain_select(gain));

   // ==================================================================
   // Reporting and bus helpers
   task automatic tally_and_finish();
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic xf(input logic wr, input logic [7:0] a, input logic [7:0] d);
      logic t;
      dlecr_mcu_inst.xfer(wr, a, {24'h0, d}, r, e, t);
      if (t) begin
         num_errors++;
         tally_and_finish();
      end
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [7:0] exp);
      xf(1'b0, a, 8'h00);
      chk(nm, r, {24'h0, exp});
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rchk("link rst", A_LINK, 8'h93);
      chk("sleep", sleep, 1);
      rchk("eq rst", A_EQ, 8'h29);
      chk("gain", gain, 4'h9);
      lock <= 1'b0;
      xf(1'b1, A_LINK, 8'hff);
      rchk("link ro", A_LINK, 8'h7f);
      chk("ctl", {odis, prbs, sleep, back, fore}, 5'h1f);
      xf(1'b1, A_LINK, 8'h00);
      rchk("link clr", A_LINK, 8'h00);
      chk("ctl0", {odis, prbs, sleep, back, fore}, 5'h00);
      for (int c = 0; c < 4; c++) begin
         xf(1'b1, A_LINK, {4'h0, c[1:0], 2'b00});
         // Write lands on the completing edge; look once it has settled
         @(negedge pclk);
         chk("ifsel", {ifs, i2c_en, uart_en}, {c[1:0], c == 0, c == 1});
      end
      for (int c = 0; c < 4; c++) begin
         xf(1'b1, A_EQ, {1'b1, c[1:0], 5'h1b});
         rchk("eq", A_EQ, {1'b1, c[1:0], 5'h1b});
         chk("eqo", {cmd, cut, bdis, gain}, {1'b1, c[1:0], 5'h1b});
      end
      // Forbidden gain keeps the old code, other fields still land
      xf(1'b1, A_EQ, 8'h0c);
      rchk("gain bad", A_EQ, 8'h0b);
      xf(1'b1, A_EQ, 8'h00);
      rchk("gain min", A_EQ, 8'h00);
      xf(1'b1, 8'h18, 8'hff);
      chk("err wr", e, 1);
      rchk("unmapped", 8'h18, 8'h00);
      chk("err rd", e, 1);
      rchk("link kept", A_LINK, 8'h0c);
      // Second reset with control direction and equalizer default pins flipped
      @(posedge pclk);
      presetn <= 1'b0;
      cdir <= 1'b0;
      eqd <= 1'b1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk("link rst2", A_LINK, 8'h03);
      rchk("eq rst2", A_EQ, 8'h24);
      tally_and_finish();
   end
endmodule // dlecr_regs_tb
